// *** rtl/pwm_auto_shutdown_deadband.sv ***
// pwm auto-shutdown and half-bridge dead-band stage with axi4-lite registers
// assumes the pwm core supplies pwm_raw and period_start on aclk; fault inputs are asynchronous
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps

// Operation
// RL1 - event flag bit 7 shows shutdown state
// RL2 - source select 000 disables auto-shutdown
// RL3 - 001/010/011 select comparator faults
// RL4 - 100..111 add low external pin fault
// RL5 - pair a/c shutdown: low, high, tristate
// RL6 - pair b/d shutdown: low, high, tristate
// RL7 - shutdown is level sensitive while fault present
// RL8 - flag writes ignored while fault persists
// RL9 - resume only at next pwm period start
// RL10 - auto restart only when restart enable set
// RL11 - auto restart clears flag when fault gone
// RL12 - dead-band delays only inactive-to-active edges
// RL13 - delay from pwm control low seven bits
// RL14 - event sets flag and forces pins
// RL15 - software writing one forces shutdown
// RL16 - without restart software clears flag
// RL17 - zero dead-band count adds no delay
// RL18 - fault inputs synchronised before flag update
module pwm_auto_shutdown_deadband
   import pwm_shutdown_pkg::*;
#(
   parameter int delay_width = 7
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pwm core
   input  wire logic        pwm_raw,
   input  wire logic        period_start,
   // fault sources
   input  wire logic        comparator_one,
   input  wire logic        comparator_two,
   input  wire logic        ext_fault_pin,
   // output pins, oe low while driving
   output logic             pwm_out_a,
   output logic             pwm_out_a_oe_n,
   output logic             pwm_out_b,
   output logic             pwm_out_b_oe_n,
   output logic             pwm_out_c,
   output logic             pwm_out_c_oe_n,
   output logic             pwm_out_d,
   output logic             pwm_out_d_oe_n,
   // interrupt
   output logic             irq
);

   // ------------------------------------------------------------
   // fault synchronisers
   // ------------------------------------------------------------
   logic [2:0] fault_meta_reg;
   logic [2:0] fault_sync_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_meta_reg <= 3'h7;
         fault_sync_reg <= 3'h7;
      end else begin
         fault_meta_reg <= {ext_fault_pin, comparator_two, comparator_one};
         fault_sync_reg <= fault_meta_reg;                               // [RL18]
      end
   end

   wire cmp1_s = fault_sync_reg[0];
   wire cmp2_s = fault_sync_reg[1];
   // the pin fault is active low; reset value of 1 means no fault
   wire pin_fault_s = ~fault_sync_reg[2];
   // fault to pin latency is three clocks: two sync stages plus the output register

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic       event_flag_reg;
   logic [2:0] src_sel_reg;
   logic [1:0] ac_state_reg;
   logic [1:0] bd_state_reg;
   logic       restart_en_reg;
   logic [delay_width-1:0] delay_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_mask_reg;
   logic       running_reg;

   function automatic logic fault_select(input logic [2:0] sel, input logic c1, input logic c2, input logic pin);
      logic cmp;
      cmp = (sel[0] & c1) | (sel[1] & c2);                                // [RL3]
      fault_select = cmp | (sel[2] & pin);                                // [RL4]
   endfunction : fault_select

   // 000 yields no fault term at all, so auto-shutdown is off
   wire fault_active = fault_select(src_sel_reg, cmp1_s, cmp2_s, pin_fault_s); // [RL2] [RL7]

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   logic        aw_held_reg;
   logic        w_held_reg;
   logic [3:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;

   // the write readies toggle while idle, so a waiting master is taken within two clocks
   // only byte lane 0 carries state; the other strobe lanes are ignored
   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire aw_have  = aw_held_reg | aw_take;
   wire w_have   = w_held_reg | w_take;
   wire wr_fire  = aw_have & w_have & ~s_axi_bvalid;
   wire [3:0]  wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
   wire        wr_lane0 = w_held_reg ? wstrb_reg[0] : s_axi_wstrb[0];
   wire        wr_ok   = (wr_addr == addr_shutdown_ctrl) | (wr_addr == addr_pwm_ctrl) |
                         (wr_addr == addr_irq_status) | (wr_addr == addr_irq_mask);
   wire wr_sd   = wr_fire & wr_lane0 & (wr_addr == addr_shutdown_ctrl);
   wire wr_pc   = wr_fire & wr_lane0 & (wr_addr == addr_pwm_ctrl);
   wire wr_is   = wr_fire & wr_lane0 & (wr_addr == addr_irq_status);
   wire wr_im   = wr_fire & wr_lane0 & (wr_addr == addr_irq_mask);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         awaddr_reg    <= 4'h0;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= resp_okay;
      end else begin
         s_axi_awready <= ~aw_have & ~s_axi_awready;
         s_axi_wready  <= ~w_have & ~s_axi_wready;
         if (aw_take) begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         aw_held_reg <= aw_have & ~wr_fire;
         w_held_reg  <= w_have & ~wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? resp_okay : resp_slverr;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire [7:0] sd_view = {event_flag_reg, src_sel_reg, ac_state_reg, bd_state_reg};
   wire [7:0] pc_view = {restart_en_reg, delay_reg};
   wire rd_ok = (s_axi_araddr == addr_shutdown_ctrl) | (s_axi_araddr == addr_pwm_ctrl) |
                (s_axi_araddr == addr_irq_status) | (s_axi_araddr == addr_irq_mask);
   wire [31:0] rd_mux = (s_axi_araddr == addr_shutdown_ctrl) ? {24'h000000, sd_view} :
                        (s_axi_araddr == addr_pwm_ctrl)      ? {24'h000000, pc_view} :
                        (s_axi_araddr == addr_irq_status)    ? {30'h0, irq_status_reg} :
                        (s_axi_araddr == addr_irq_mask)      ? {30'h0, irq_mask_reg} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= resp_okay;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? resp_okay : resp_slverr;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // shutdown flag and restart
   // ------------------------------------------------------------
   wire sw_flag_val = wr_data[event_flag_bit];
   // flag write is ignored while a fault persists; a one written is a shutdown source
   wire sw_set      = wr_sd & sw_flag_val;                                // [RL15]
   wire sw_clear    = wr_sd & ~sw_flag_val & ~fault_active;               // [RL8] [RL16]
   wire auto_clear  = restart_en_reg & ~fault_active & event_flag_reg;    // [RL10] [RL11]
   // set terms win over both clears, so a fault that meets a clear keeps the pins parked
   wire flag_next   = fault_active | sw_set |
                      (event_flag_reg & ~sw_clear & ~auto_clear);         // [RL14]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_flag_reg <= shutdown_ctrl_reset[event_flag_bit];
         src_sel_reg    <= shutdown_ctrl_reset[src_sel_hi:src_sel_lo];
         ac_state_reg   <= shutdown_ctrl_reset[ac_state_hi:ac_state_lo];
         bd_state_reg   <= shutdown_ctrl_reset[bd_state_hi:bd_state_lo];
         restart_en_reg <= pwm_ctrl_reset[restart_en_bit];
         delay_reg      <= pwm_ctrl_reset[delay_hi:delay_lo];
         irq_mask_reg   <= irq_reset;
      end else begin
         event_flag_reg <= flag_next;                                     // [RL1]
         if (wr_sd) begin
            src_sel_reg  <= wr_data[src_sel_hi:src_sel_lo];
            ac_state_reg <= wr_data[ac_state_hi:ac_state_lo];
            bd_state_reg <= wr_data[bd_state_hi:bd_state_lo];
         end
         if (wr_pc) begin
            restart_en_reg <= wr_data[restart_en_bit];
            delay_reg      <= wr_data[delay_hi:delay_lo];                 // [RL13]
         end
         if (wr_im) begin
            irq_mask_reg <= wr_data[1:0];
         end
      end
   end

   // outputs stay parked after the flag drops until the pwm period begins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         running_reg <= 1'b0;
      end else if (flag_next) begin
         running_reg <= 1'b0;
      end else if (period_start) begin
         running_reg <= 1'b1;                                             // [RL9]
      end
   end

   // ------------------------------------------------------------
   // interrupt status: set wins over write-one-to-clear
   // ------------------------------------------------------------
   // irq uses the next status so it rises in the same clock as the status bit
   wire [1:0] irq_events = {auto_clear, flag_next & ~event_flag_reg};
   wire [1:0] irq_wclr   = wr_is ? wr_data[1:0] : 2'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= irq_reset;
         irq            <= 1'b0;
      end else begin
         irq_status_reg <= irq_events | (irq_status_reg & ~irq_wclr);
         irq            <= |((irq_events | (irq_status_reg & ~irq_wclr)) & irq_mask_reg);
      end
   end

   // ------------------------------------------------------------
   // half-bridge dead band
   // ------------------------------------------------------------
   // a is active on pwm high, b on pwm low; only the rising edge of each is delayed
   logic                   pwm_prev_reg;
   logic [delay_width-1:0] dead_cnt_reg;
   logic                   a_gate_reg;
   logic                   b_gate_reg;

   // step size is a package constant taken off the count each clock, so a larger value shortens the delay
   wire edge_seen = pwm_raw ^ pwm_prev_reg;
   wire dead_done = (dead_cnt_reg == '0);
   wire zero_dly  = (delay_reg == '0);                                     // [RL17]
   // an edge during the count restarts it, so a pulse shorter than the delay never turns a switch on

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_prev_reg <= 1'b0;
         dead_cnt_reg <= '0;
         a_gate_reg   <= 1'b0;
         b_gate_reg   <= 1'b0;
      end else begin
         pwm_prev_reg <= pwm_raw;
         if (edge_seen) begin
            dead_cnt_reg <= zero_dly ? '0 : delay_reg - delay_width'(delay_step_cycles); // [RL12] [RL13]
            a_gate_reg   <= pwm_raw & zero_dly;
            b_gate_reg   <= ~pwm_raw & zero_dly;
         end else if (!dead_done) begin
            dead_cnt_reg <= dead_cnt_reg - delay_width'(delay_step_cycles);
         end else begin
            a_gate_reg <= pwm_raw;
            b_gate_reg <= ~pwm_raw;
         end
      end
   end

   // ------------------------------------------------------------
   // pin forcing
   // ------------------------------------------------------------
   function automatic logic [1:0] park(input logic [1:0] st);
      // returns {oe_n, level}: 1x releases the pin, else drive bit 0
      park = st[1] ? 2'b10 : {1'b0, st[0]};
   endfunction : park

   // a running pair is always driven; only a parked pair may be released
   wire parked = flag_next | ~running_reg;
   wire [1:0] ac_pin = parked ? park(ac_state_reg) : {1'b0, 1'b0};        // [RL5]
   wire [1:0] bd_pin = parked ? park(bd_state_reg) : {1'b0, 1'b0};        // [RL6]

   // forcing registers the next-cycle flag so it lands at the same edge as the flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_out_a      <= 1'b0;
         pwm_out_c      <= 1'b0;
         pwm_out_b      <= 1'b0;
         pwm_out_d      <= 1'b0;
         pwm_out_a_oe_n <= 1'b1;
         pwm_out_c_oe_n <= 1'b1;
         pwm_out_b_oe_n <= 1'b1;
         pwm_out_d_oe_n <= 1'b1;
      end else begin
         pwm_out_a      <= parked ? ac_pin[0] : a_gate_reg;               // [RL14]
         pwm_out_c      <= parked ? ac_pin[0] : a_gate_reg;
         pwm_out_b      <= parked ? bd_pin[0] : b_gate_reg;
         pwm_out_d      <= parked ? bd_pin[0] : b_gate_reg;
         pwm_out_a_oe_n <= ac_pin[1];
         pwm_out_c_oe_n <= ac_pin[1];
         pwm_out_b_oe_n <= bd_pin[1];
         pwm_out_d_oe_n <= bd_pin[1];
      end
   end

endmodule : pwm_auto_shutdown_deadband

// *** rtl/pwm_shutdown_pkg.sv ***
// package: register map, field positions, reset values and timing for the pwm auto-shutdown block
// assumes a 32-bit axi4-lite register bus and a 25 MHz system clock
package pwm_shutdown_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [3:0] addr_shutdown_ctrl = 4'h0;
   localparam logic [3:0] addr_pwm_ctrl      = 4'h4;
   localparam logic [3:0] addr_irq_status    = 4'h8;
   localparam logic [3:0] addr_irq_mask      = 4'hC;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int event_flag_bit   = 7;
   localparam int src_sel_hi       = 6;
   localparam int src_sel_lo       = 4;
   localparam int ac_state_hi      = 3;
   localparam int ac_state_lo      = 2;
   localparam int bd_state_hi      = 1;
   localparam int bd_state_lo      = 0;
   localparam int restart_en_bit   = 7;
   localparam int delay_hi         = 6;
   localparam int delay_lo         = 0;
   localparam int irq_shutdown_bit = 0;
   localparam int irq_restart_bit  = 1;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] shutdown_ctrl_reset = 8'h00;
   localparam logic [7:0] pwm_ctrl_reset      = 8'h00;
   localparam logic [1:0] irq_reset           = 2'h0;

   // ------------------------------------------------------------
   // axi responses and timing
   // ------------------------------------------------------------
   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   // one delay step is one instruction cycle of the pwm core, one sys clock here
   localparam int         delay_step_cycles = 1;
endpackage : pwm_shutdown_pkg

// *** verification/pwm_auto_shutdown_deadband_bench.sv ***
// bench: register tasks, fault stimulus and inline expected values for the auto-shutdown stage
// assumes one clock; the bridge model resolves pin levels and fault lines
`timescale 1ns/100ps
`define chk(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %0h seen %0h", nm, e, a); end end
module pwm_auto_shutdown_deadband_bench
   import pwm_shutdown_pkg::*;
;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0]  awaddr = 0, wstrb = 0, araddr = 0;
   logic [31:0] wdata = 0, rd_d;
   logic        pwm_raw = 0, period_start = 0, exp_f;
   logic [2:0]  fault_cmd = 0;
   logic [1:0]  rd_r, wr_r;
   logic [6:0]  ctl;
   wire         awready, wready, bvalid, arready, rvalid, irq, c1, c2, ext;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [3:0]  lvl, oe_n, gate;
   int          fail_count = 0, n_checks = 0, t_on, t_off, seed;
   int          delays[4] = '{0, 1, 5, 127};
   always #20 aclk = ~aclk;
   pwm_auto_shutdown_deadband dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_raw(pwm_raw), .period_start(period_start),
      .comparator_one(c1), .comparator_two(c2), .ext_fault_pin(ext), .pwm_out_a(lvl[0]), .pwm_out_a_oe_n(oe_n[0]),
      .pwm_out_b(lvl[1]), .pwm_out_b_oe_n(oe_n[1]), .pwm_out_c(lvl[2]), .pwm_out_c_oe_n(oe_n[2]),
      .pwm_out_d(lvl[3]), .pwm_out_d_oe_n(oe_n[3]), .irq(irq));
   pwm_bridge_model far (.fault_cmd(fault_cmd), .pin_level(lvl), .pin_oe_n(oe_n), .comparator_one(c1),
      .comparator_two(c2), .ext_fault_pin(ext), .gate_level(gate));
   // -----------------------------------------------
   // bus and stimulus tasks
   // -----------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         wr_r = bresp;
         if (bvalid) break;
      end
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         rd_d = rdata;
         rd_r = rresp;
         if (rvalid) break;
      end
      rready <= 1'b0;
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick
   task automatic pulse();
      @(posedge aclk);
      period_start <= 1'b1;
      @(posedge aclk);
      period_start <= 1'b0;
   endtask : pulse
   task automatic chk_ctl();
      rd(addr_shutdown_ctrl);
      `chk("shutdown_ctrl", {24'h0, exp_f, ctl}, rd_d)
   endtask : chk_ctl
   task automatic end_of_test();
      if (fail_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      end_of_test();
   end
   // -----------------------------------------------
   // tests
   // -----------------------------------------------
   initial begin
      seed = $urandom(32'h3e22);
      tick(2);
      aresetn <= 1'b1;
      for (int r = 0; r < 16; r += 4) begin
         rd(r[3:0]);
         `chk("reset_value", 32'h0, rd_d)
      end
      rd(4'h1);
      `chk("unmapped_resp", resp_slverr, rd_r)
      wr(4'h2, 32'hFF);
      `chk("unmapped_wresp", resp_slverr, wr_r)
      wr(addr_irq_mask, 32'h3);
      `chk("write_resp", resp_okay, wr_r)
      pulse();
      for (int s = 0; s < 8; s++) for (int k = 0; k < 3; k++) begin
         ctl = {s[2:0], 4'($urandom)};
         exp_f = |(s[2:0] & (3'h1 << k));
         wr(addr_shutdown_ctrl, {25'h0, ctl});
         fault_cmd <= 3'h1 << k;
         tick(6);
         chk_ctl();
         `chk("irq", exp_f, irq)
         if (exp_f) begin
            `chk("oe_ac", ctl[3], oe_n[0])
            `chk("lvl_ac", ctl[3] ? 1'b0 : ctl[2], gate[2])
            `chk("oe_bd", ctl[1], oe_n[3])
            `chk("lvl_bd", ctl[1] ? 1'b0 : ctl[0], gate[1])
            `chk("lvl_d", ctl[1] ? 1'b0 : ctl[0], gate[3])
            wr(addr_shutdown_ctrl, {25'h0, ctl});
            chk_ctl();
         end
         fault_cmd <= 3'h0;
         tick(6);
         chk_ctl();
         wr(addr_shutdown_ctrl, {25'h0, ctl});
         exp_f = 1'b0;
         chk_ctl();
         wr(addr_irq_status, 32'h3);
         tick(2);
         `chk("irq_clear", 1'b0, irq)
         pulse();
      end
      // auto restart, then the masked interrupt stays low
      wr(addr_pwm_ctrl, 32'h80);
      ctl = 7'h10;
      exp_f = 1'b1;
      wr(addr_shutdown_ctrl, 32'h10);
      fault_cmd <= 3'h1;
      tick(6);
      chk_ctl();
      fault_cmd <= 3'h0;
      tick(6);
      exp_f = 1'b0;
      chk_ctl();
      rd(addr_irq_status);
      `chk("irq_status", 32'h3, rd_d)
      wr(addr_irq_mask, 32'h0);
      tick(2);
      `chk("irq_masked", 1'b0, irq)
      wr(addr_irq_status, 32'h3);
      wr(addr_irq_mask, 32'h3);
      // software forced shutdown with source off, resume waits for a period start
      wr(addr_pwm_ctrl, 32'h0);
      ctl = 7'h0A;
      exp_f = 1'b1;
      wr(addr_shutdown_ctrl, 32'h8A);
      tick(3);
      chk_ctl();
      `chk("oe_forced", 4'hF, oe_n)
      exp_f = 1'b0;
      wr(addr_shutdown_ctrl, 32'h0A);
      tick(4);
      `chk("oe_waits", 4'hF, oe_n)
      pulse();
      tick(2);
      `chk("oe_resumed", 4'h0, oe_n)
      // dead band on both edges of the raw waveform
      foreach (delays[k]) begin
         wr(addr_pwm_ctrl, delays[k]);
         rd(addr_pwm_ctrl);
         `chk("pwm_ctrl", delays[k], rd_d)
         for (int e = 0; e < 2; e++) begin
            tick(135);
            pwm_raw <= !e;
            t_on = -1;
            t_off = -1;
            for (int i = 0; i < 200 && t_on < 0; i++) begin
               @(posedge aclk);
               if (t_off < 0 && gate[1 - e] === 1'b0) t_off = i;
               if (gate[e] === 1'b1) t_on = i;
            end
            `chk("dead_band", delays[k], t_on - t_off)
         end
      end
      end_of_test();
   end
endmodule : pwm_auto_shutdown_deadband_bench

// *** verification/pwm_bridge_model.sv ***
// far side: fault comparators, external fault pin and bridge gate inputs
// assumes the bench commands fault levels; pins are indexed a, b, c, d
`timescale 1ns/100ps
module pwm_bridge_model (
   // fault command: bit0 comparator one, bit1 comparator two, bit2 pin low
   input  wire logic [2:0] fault_cmd,
   // pins of the stage
   input  wire logic [3:0] pin_level,
   input  wire logic [3:0] pin_oe_n,
   // fault lines and gate levels
   output logic            comparator_one,
   output logic            comparator_two,
   output logic            ext_fault_pin,
   output logic [3:0]      gate_level
);
   assign comparator_one = fault_cmd[0];
   assign comparator_two = fault_cmd[1];
   // the fault pin has a pull-up, so no fault reads high
   assign ext_fault_pin  = !fault_cmd[2];
   // a released pin falls to the pull-down that keeps its switch off
   assign gate_level     = pin_level & ~pin_oe_n;
endmodule : pwm_bridge_model

// *** verification/pwm_shutdown_asserts.sv ***
// checker: bus answers, pin parking and resume timing of the auto-shutdown stage
// assumes the master offers write address and data together
`timescale 1ns/100ps
module pwm_shutdown_asserts
   import pwm_shutdown_pkg::*;
(
   input wire logic        aclk, aresetn,
   input wire logic [3:0]  s_axi_awaddr, s_axi_wstrb,
   input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic [31:0] s_axi_wdata, s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic        period_start, comparator_one, comparator_two, ext_fault_pin,
   input wire logic        pwm_out_a, pwm_out_a_oe_n, pwm_out_c_oe_n,
   input wire logic        pwm_out_b, pwm_out_b_oe_n, pwm_out_d_oe_n
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // -----------------------------------------------
   // shadow of the control fields, loaded at the same edge as the register
   // -----------------------------------------------
   logic [6:0] ctl_reg;
   logic [6:0] ctl_next;
   logic       fault;
   logic       take_w;
   assign take_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign ctl_next = (take_w && s_axi_awaddr == addr_shutdown_ctrl && s_axi_wstrb[0]) ? s_axi_wdata[6:0] : ctl_reg;
   assign fault = |(ctl_reg[6:4] & {!ext_fault_pin, comparator_two, comparator_one});
   always_ff @(posedge aclk) begin
      if (!aresetn) ctl_reg <= 7'h00;
      else ctl_reg <= ctl_next;
   end
   // -----------------------------------------------
   // properties
   // -----------------------------------------------
   a_park_ac: assert property ((fault && $stable(ctl_reg)) [*4] |->
      pwm_out_a_oe_n == ctl_reg[3] && (ctl_reg[3] || pwm_out_a == ctl_reg[2])) else $error("pair ac not parked");
   a_park_bd: assert property ((fault && $stable(ctl_reg)) [*4] |->
      pwm_out_b_oe_n == ctl_reg[1] && (ctl_reg[1] || pwm_out_b == ctl_reg[0])) else $error("pair bd not parked");
   a_resume_period: assert property ($fell(pwm_out_a_oe_n) && ctl_reg[3] && $past(ctl_reg[3], 2) |->
      $past(period_start) || $past(period_start, 2)) else $error("pins resumed off period start");
   a_pair_oe: assert property (pwm_out_a_oe_n == pwm_out_c_oe_n && pwm_out_b_oe_n == pwm_out_d_oe_n)
      else $error("pair enables differ");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   a_write_answer: assert property (take_w |=> s_axi_bvalid) else $error("write answer late");
   a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
   a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == resp_slverr |-> s_axi_rdata == 32'h0)
      else $error("refused read data not zero");
   a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
endmodule : pwm_shutdown_asserts

bind pwm_auto_shutdown_deadband pwm_shutdown_asserts chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_wstrb,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_rdata, .s_axi_rresp,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .period_start, .comparator_one,
   .comparator_two, .ext_fault_pin, .pwm_out_a, .pwm_out_a_oe_n, .pwm_out_c_oe_n, .pwm_out_b,
   .pwm_out_b_oe_n, .pwm_out_d_oe_n);
